// [include/wdt_pkg.sv]
// watchdog package: control register map, reset value, field positions
// and the crystal timebase used by the timeout counter.
// assumes nothing beyond a SystemVerilog compiler.
package wdt_pkg;
   // -----------------------------------------------------------------
   // control register map
   // -----------------------------------------------------------------
   localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hc0; // byte address, bits c0..c7
   localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h10; // prescale 1, all else 0
   localparam int PRE_MSB = 7;
   localparam int PRE_LSB = 4;
   localparam int INTERRUPT_RESPONSE_SELECT_BIT = 3;
   localparam int STATUS_BIT = 2;
   localparam int ENABLE_BIT = 1;
   localparam int UNLOCK_BIT = 0;
   localparam logic [3:0] PRE_IMMEDIATE = 4'h8; // zero timeout code
   localparam logic [3:0] PRE_MAX_TIMED = 4'h7;

   // -----------------------------------------------------------------
   // timebase: period = 2^pre * 2^9 crystal periods
   // -----------------------------------------------------------------
   localparam int XTAL_HZ = 32768;
   localparam int SYS_HZ = 10000000;
   localparam int BASE_SHIFT = 9;
   localparam int CNT_W = BASE_SHIFT + 8; // holds 2^16 crystal ticks
   localparam int SYNC_STAGES = 2;

   // write unlock window state, gray along locked -> armed
   typedef enum logic {
      UNLOCK_LOCKED = 1'b0,
      UNLOCK_ARMED = 1'b1
   } unlock_e;
endpackage

// [rtl/xtal_tick_sync.sv]
// crystal clock pin resynchronised to clk_sys, one pulse per rising edge.
// assumes the crystal is far slower than clk_sys (32 khz against 10 mhz).
`timescale 1ns/1ps
module xtal_tick_sync
   import wdt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic xtal_clk,
   output logic xtal_tick
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // two flops before anything looks at the pin
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= xtal_clk;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // rising edge of the synchronised crystal
   assign xtal_tick = sync_reg && !last_reg;
endmodule

// [rtl/wdt_counter.sv]
// watchdog period counter advanced by crystal ticks.
// assumes tick is a one-cycle pulse on clk_sys; clear has priority.
`timescale 1ns/1ps
module wdt_counter
   import wdt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [2:0] prescale,
   output logic expire
);
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] limit;

   // last count of the period: 2^(pre+9) - 1
   assign limit = CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1}
                    << (BASE_SHIFT + int'(prescale))) - 1);
   // >= keeps a shortened period from wrapping past its end
   assign expire = run && !clear && tick && (count_reg >= limit);

   // tick counter, restarted on kick, expiry or while stopped
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         count_reg <= '0;
      end else if (clear || !run || expire) begin
         count_reg <= '0;
      end else if (tick) begin
         count_reg <= count_reg + 1'b1;
      end
   end
endmodule

// [rtl/watchdog_timer_control.sv]
// watchdog timer with one control register on the special function bus.
// assumes the core strobes byte and bit writes for one clk_sys cycle,
// pulses instr_retire once per finished instruction (with any write
// strobe of that instruction) and turns reset requests into a system
// reset that does not touch resetn of this block.
`timescale 1ns/1ps

module watchdog_timer_control
   import wdt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic xtal_clk,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [7:0] sfr_bit_addr,
   input wire logic sfr_bit_val,
   input wire logic instr_retire,
   input wire logic supply_monitor_irq,
   output logic [7:0] sfr_rdata,
   output logic wdt_irq,
   output logic wdt_reset_req
);
   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   unlock_e unlock_reg;
   logic [3:0] prescale_reg;
   logic interrupt_response_select_reg;
   logic status_reg;
   logic enable_reg;
   logic irq_reg;
   logic reset_req_reg;
   logic [7:0] rdata_reg;
   logic [7:0] ctrl_value;
   logic [7:0] wr_data;
   logic byte_hit;
   logic bit_hit;
   logic reg_hit;
   logic accept;
   logic arm;
   logic xtal_tick;
   logic run;
   logic kick;
   logic expire;
   logic immediate;
   logic timeout;
   logic hw_disable;

   // -----------------------------------------------------------------
   // register access decode
   // -----------------------------------------------------------------
   // byte write at c0, bit writes at c0..c7
   assign byte_hit = sfr_wr && (sfr_addr == WATCHDOG_CONTROL_ADDR);
   assign bit_hit = sfr_bit_wr && (sfr_bit_addr[7:3] == WATCHDOG_CONTROL_ADDR[7:3]);
   assign reg_hit = byte_hit || bit_hit;

   // current register image, unlock bit reads as the open window
   assign ctrl_value = {prescale_reg, interrupt_response_select_reg, status_reg, enable_reg,
                        unlock_reg == UNLOCK_ARMED};

   // bit writes merge one bit into the current image
   always_comb begin
      wr_data = ctrl_value;
      if (byte_hit) begin
         wr_data = sfr_wdata;
      end else if (bit_hit) begin
         wr_data[sfr_bit_addr[2:0]] = sfr_bit_val;
      end
   end

   // a write counts only while the window is open
   assign accept = reg_hit && (unlock_reg == UNLOCK_ARMED);
   assign arm = reg_hit && (unlock_reg == UNLOCK_LOCKED)
                && wr_data[UNLOCK_BIT];

   // -----------------------------------------------------------------
   // write unlock window
   // -----------------------------------------------------------------
   // armed by setting the unlock bit, closed by the next write or by
   // any later instruction that is not a write to the register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         unlock_reg <= UNLOCK_LOCKED;
      end else begin
         case (unlock_reg)
            UNLOCK_LOCKED: begin
               if (arm) begin
                  unlock_reg <= UNLOCK_ARMED;
               end
            end
            UNLOCK_ARMED: begin
               if (accept || instr_retire) begin
                  unlock_reg <= UNLOCK_LOCKED;
               end
            end
            default: begin
               unlock_reg <= UNLOCK_LOCKED;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // timeout machinery
   // -----------------------------------------------------------------
   // crystal pin resynchronised into clk_sys before counting
   xtal_tick_sync u_tick (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .xtal_clk(xtal_clk),
      .xtal_tick(xtal_tick)
   );

   // a written one to enable kicks the counter back to zero
   assign kick = accept && wr_data[ENABLE_BIT];
   assign run = enable_reg && (prescale_reg <= PRE_MAX_TIMED);
   // codes 1000b and up give zero timeout
   assign immediate = enable_reg && (prescale_reg >= PRE_IMMEDIATE);
   assign timeout = expire || immediate;
   assign hw_disable = supply_monitor_irq
                       || (timeout && (!interrupt_response_select_reg || immediate));

   // period counter, 2^pre * 512 crystal ticks
   wdt_counter u_count (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tick(xtal_tick),
      .run(run),
      .clear(kick),
      .prescale(prescale_reg[2:0]),
      .expire(expire)
   );

   // -----------------------------------------------------------------
   // control fields
   // -----------------------------------------------------------------
   // prescale and response select, written through the window only
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prescale_reg <= WATCHDOG_CONTROL_RESET[PRE_MSB:PRE_LSB];
         interrupt_response_select_reg <= WATCHDOG_CONTROL_RESET[INTERRUPT_RESPONSE_SELECT_BIT];
      end else if (accept) begin
         prescale_reg <= wr_data[PRE_MSB:PRE_LSB];
         interrupt_response_select_reg <= wr_data[INTERRUPT_RESPONSE_SELECT_BIT];
      end
   end

   // enable: hardware clears win over a software kick in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         enable_reg <= WATCHDOG_CONTROL_RESET[ENABLE_BIT];
      end else if (hw_disable) begin
         enable_reg <= 1'b0;
      end else if (accept) begin
         enable_reg <= wr_data[ENABLE_BIT];
      end
   end

   // status: set by timeout, set wins over a written zero; only a written
   // zero or the external reset clears it, a watchdog reset request does not
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         status_reg <= WATCHDOG_CONTROL_RESET[STATUS_BIT];
      end else if (timeout) begin
         status_reg <= 1'b1;
      end else if (accept && !wr_data[STATUS_BIT]) begin
         status_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // responses toward the core
   // -----------------------------------------------------------------
   // interrupt on every period when response select is set; the counter
   // restarts itself so this doubles as an interval timer
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= expire && interrupt_response_select_reg;
      end
   end

   // reset request pulse; it never reaches resetn here so status holds
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         reset_req_reg <= 1'b0;
      end else begin
         reset_req_reg <= timeout && (!interrupt_response_select_reg || immediate);
      end
   end

   assign wdt_irq = irq_reg;
   assign wdt_reset_req = reset_req_reg;

   // -----------------------------------------------------------------
   // read data
   // -----------------------------------------------------------------
   // register image one cycle after the address, zero elsewhere
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else if (sfr_addr == WATCHDOG_CONTROL_ADDR) begin
         rdata_reg <= ctrl_value;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign sfr_rdata = rdata_reg;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   AST_RESET_VALUE: assert property (
      $past(!resetn) |-> (ctrl_value == WATCHDOG_CONTROL_RESET))
      else $error("control register not at reset value");

   AST_IRQ_ON_EXPIRE: assert property (
      (expire && interrupt_response_select_reg) |=> (wdt_irq && !wdt_reset_req))
      else $error("interrupt response missing");

   AST_RESET_ON_EXPIRE: assert property (
      (expire && !interrupt_response_select_reg) |=> (wdt_reset_req && !wdt_irq && !enable_reg))
      else $error("reset response missing");

   AST_IMMEDIATE: assert property (
      (enable_reg && prescale_reg == PRE_IMMEDIATE) |=> wdt_reset_req)
      else $error("zero timeout code gave no reset");

   AST_STATUS_SET: assert property (
      timeout |=> status_reg)
      else $error("status flag not set by timeout");

   AST_STATUS_STICKY: assert property (
      (status_reg && !(accept && !wr_data[STATUS_BIT])) |=> status_reg)
      else $error("status flag lost without a written zero");

   AST_LOCKED_IGNORED: assert property (
      (reg_hit && unlock_reg == UNLOCK_LOCKED)
      |=> ($stable(prescale_reg) && $stable(interrupt_response_select_reg)))
      else $error("locked write changed the register");

   AST_WINDOW_ONCE: assert property (
      accept |=> (unlock_reg == UNLOCK_LOCKED))
      else $error("unlock window stayed open");

   AST_KICK: assert property (
      (kick && !hw_disable) |=> (enable_reg && !expire))
      else $error("kick did not enable and restart");

   AST_SUPPLY_DISABLE: assert property (
      supply_monitor_irq |=> !enable_reg)
      else $error("supply monitor did not disable");

   AST_STATUS_CLEAR: assert property (
      (accept && !wr_data[STATUS_BIT] && !timeout) |=> !status_reg)
      else $error("written zero did not clear status");

   AST_WINDOW_CLOSE: assert property (
      (unlock_reg == UNLOCK_ARMED && instr_retire)
      |=> (unlock_reg == UNLOCK_LOCKED))
      else $error("window open after another instruction");

   AST_FIELDS_HOLD: assert property (
      !accept |=> ($stable(prescale_reg) && $stable(interrupt_response_select_reg)))
      else $error("control fields changed without a write");

   AST_READ_IMAGE: assert property (
      (sfr_addr == WATCHDOG_CONTROL_ADDR) |=> (sfr_rdata == $past(ctrl_value)))
      else $error("read data not the register image");

   AST_READ_OTHER: assert property (
      (sfr_addr != WATCHDOG_CONTROL_ADDR) |=> (sfr_rdata == 8'h00))
      else $error("read data not zero for other address");

   AST_ONE_RESPONSE: assert property (
      !(wdt_irq && wdt_reset_req))
      else $error("interrupt and reset raised together");

   COV_UNLOCK_WRITE: cover property (arm ##1 accept);
   COV_INTERVAL: cover property (wdt_irq ##[1:300] enable_reg);
   COV_WDT_RESET: cover property (expire && !interrupt_response_select_reg);
   COV_STATUS_RACE: cover property (timeout && accept);
endmodule

// [tb/core_model.sv]
// processor core stand-in driving the special function register bus.
// assumes clk_sys from the bench; changes its outputs at falling edges.
`timescale 1ns/1ps
module core_model
   import wdt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [7:0] sfr_rdata,
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic [7:0] sfr_wdata,
   output logic sfr_bit_wr,
   output logic [7:0] sfr_bit_addr,
   output logic sfr_bit_val,
   output logic instr_retire
);
   logic global_interrupt_enable = 1'b1;
   // one instruction slot: optional unlock bit write, optional byte write
   task automatic put(input logic arm, input logic wr, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_bit_wr = arm;
      sfr_bit_addr = arm ? WATCHDOG_CONTROL_ADDR : 8'h00;
      sfr_bit_val = arm;
      sfr_wr = wr;
      sfr_addr = wr ? WATCHDOG_CONTROL_ADDR : 8'h00;
      sfr_wdata = wr ? d : ~d; // idle data is not left at the last value
      instr_retire = arm | wr;
   endtask
   // byte write without unlocking first
   task automatic locked_wr(input logic [7:0] d);
      put(1'b0, 1'b1, d);
      put(1'b0, 1'b0, 8'h00);
   endtask
   // guarded update: interrupts off, unlock, write on the next slot
   task automatic safe_wr(input logic [7:0] d);
      global_interrupt_enable = 1'b0;
      put(1'b1, 1'b0, 8'h00);
      put(1'b0, 1'b1, d);
      put(1'b0, 1'b0, 8'h00);
      global_interrupt_enable = 1'b1;
   endtask
   // one instruction slot with a single bit write, or with no write
   task automatic put_bit(input logic bit_on, input logic [7:0] ba,
                          input logic v);
      @(negedge clk_sys);
      sfr_bit_wr = bit_on;
      sfr_bit_addr = ba;
      sfr_bit_val = v;
      sfr_wr = 1'b0;
      sfr_addr = 8'h00;
      instr_retire = 1'b1;
   endtask
   // guarded single bit update through the window
   task automatic safe_bit(input logic [7:0] ba, input logic v);
      global_interrupt_enable = 1'b0;
      put(1'b1, 1'b0, 8'h00);
      put_bit(1'b1, ba, v);
      put(1'b0, 1'b0, 8'h00);
      global_interrupt_enable = 1'b1;
   endtask
   // read: address in one cycle, data taken the cycle after
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_sys);
      sfr_addr = a;
      @(negedge clk_sys);
      v = sfr_rdata;
      sfr_addr = 8'h00;
   endtask
   initial begin
      put(1'b0, 1'b0, 8'h00);
   end
endmodule

// [tb/testbench.sv]
// self-checking bench for the watchdog control block.
// assumes core_model on the bus and a fast crystal stand-in.
`timescale 1ns/1ps
module testbench
   import wdt_pkg::*;
;
   localparam int XT = 16; // clk_sys cycles per crystal period
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic xtal_clk = 1'b0;
   logic supply_monitor_irq = 1'b0;
   logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, rd_v;
   logic sfr_wr, sfr_bit_wr, sfr_bit_val, instr_retire;
   logic wdt_irq, wdt_reset_req;
   logic [31:0] n;
   int fail_count = 0;
   int check_count = 0;
   always #50 clk_sys = ~clk_sys;
   always #(XT * 50) xtal_clk = ~xtal_clk;
   core_model i_core (.clk_sys(clk_sys), .sfr_rdata(sfr_rdata),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
      .sfr_bit_val(sfr_bit_val), .instr_retire(instr_retire));
   watchdog_timer_control i_dut (.clk_sys(clk_sys), .resetn(resetn),
      .xtal_clk(xtal_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val),
      .instr_retire(instr_retire), .supply_monitor_irq(supply_monitor_irq),
      .sfr_rdata(sfr_rdata), .wdt_irq(wdt_irq),
      .wdt_reset_req(wdt_reset_req));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      i_core.rd(a, rd_v);
      check(rd_v, exp);
   endtask
   // count cycles until the chosen pulse, bounded
   task automatic wait_evt(input logic rst, input int limit);
      n = 0;
      while ((rst ? wdt_reset_req : wdt_irq) !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > limit) begin
            fail_count++;
            final_report;
         end
      end
   endtask
   // period in clk_sys cycles, within sync and crystal phase slack
   function automatic logic near(input logic [31:0] v, input int pre);
      return (v + 40 > (512 << pre) * XT) && (v < (512 << pre) * XT + 40);
   endfunction
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      rdchk(WATCHDOG_CONTROL_ADDR, WATCHDOG_CONTROL_RESET);
      rdchk(8'hc1, 8'h00);
      i_core.locked_wr(8'h0a);
      rdchk(WATCHDOG_CONTROL_ADDR, WATCHDOG_CONTROL_RESET);
      $display("test done: reset value and lock");
      // interval timer with interrupt response, prescale 0
      i_core.safe_wr(8'h0a);
      rdchk(WATCHDOG_CONTROL_ADDR, 8'h0a);
      wait_evt(1'b0, 9000);
      check(near(n, 0), 1'b1);
      check(wdt_reset_req, 1'b0);
      rdchk(WATCHDOG_CONTROL_ADDR, 8'h0e);
      wait_evt(1'b0, 9000);
      check(near(n, 0), 1'b1);
      i_core.safe_wr(8'h08);
      rdchk(WATCHDOG_CONTROL_ADDR, 8'h08);
      $display("test done: interval interrupt");
      // reset response at prescale 1, kicked part way
      i_core.safe_wr(8'h12);
      repeat (6000) @(negedge clk_sys);
      i_core.safe_wr(8'h12);
      wait_evt(1'b1, 17000);
      check(near(n, 1), 1'b1);
      check(wdt_irq, 1'b0);
      rdchk(WATCHDOG_CONTROL_ADDR, 8'h14);
      repeat (4) @(negedge clk_sys);
      resetn = 1'b0;
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      rdchk(WATCHDOG_CONTROL_ADDR, WATCHDOG_CONTROL_RESET);
      $display("test done: reset response");
      // zero timeout code, even with interrupt response
      i_core.safe_wr(8'h8a);
      wait_evt(1'b1, 4);
      check(n <= 4, 1'b1);
      i_core.rd(WATCHDOG_CONTROL_ADDR, rd_v);
      check(rd_v[ENABLE_BIT], 1'b0);
      // status cleared by a single bit write of zero
      i_core.safe_bit(8'hc2, 1'b0);
      rdchk(WATCHDOG_CONTROL_ADDR, 8'h88);
      // supply monitor event drops the enable
      i_core.safe_wr(8'h0a);
      @(negedge clk_sys);
      supply_monitor_irq = 1'b1;
      @(negedge clk_sys);
      supply_monitor_irq = 1'b0;
      i_core.rd(WATCHDOG_CONTROL_ADDR, rd_v);
      check(rd_v[ENABLE_BIT], 1'b0);
      $display("test done: immediate reset and supply monitor");
      // foreign bit write closes the window; locked writes do nothing
      i_core.put(1'b1, 1'b0, 8'h00);
      i_core.put_bit(1'b1, 8'hc8, 1'b1);
      i_core.put(1'b0, 1'b1, 8'h52);
      i_core.put_bit(1'b1, 8'hc1, 1'b1);
      i_core.put_bit(1'b0, 8'hc3, 1'b0);
      rdchk(WATCHDOG_CONTROL_ADDR, 8'h08);
      i_core.safe_bit(8'hc3, 1'b0);
      rdchk(WATCHDOG_CONTROL_ADDR, 8'h00);
      $display("test done: bit access and write window");
      final_report;
   end
endmodule
